// ---- src/rtc_device.sv ----
// Serial register access logic of the clock chip (link slave end).
// Assumes scl comes from the master and stands still outside frames;
// clk is the local system clock used for outputs and the 32 kHz pin.
//
// Functional notes
// [RQ1] Selector bit 0/1 picks status 1/2
// [RQ2] Same selector bit picks interrupt register 1/2
// [RQ3] Master leaves last read byte unacknowledged
// [RQ4] Master acknowledges every earlier read byte low
// [RQ5] Alarm mode: interrupt register is three bytes
// [RQ6] Otherwise interrupt register is one byte
// [RQ7] Frequency mode: register sets interrupt pin rate
// [RQ8] Master programs status 2 before interrupt access
// [RQ9] Never alarm and frequency output together
// [RQ10] State kept on break; stop returns idle
// [RQ11] Stop ignored while chip pulls data low
// [RQ12] Recovery: start, 63 clocks, data released
// [RQ13] Chip releases data, then stop resets interface
// [RQ14] Recovery runs at system initialization
// [RQ15] No traffic for 0.5 s after power-on
// [RQ16] Time readback within 1 s of write; no time registers here, time commands never acked
// [RQ17] Fixed 32.768 kHz square wave always driven; made from clk as about 32.81 kHz
// [RQ18] Read/write bit 1 reads; data MSB first
// [RQ19] Chip acknowledges low on ninth clock
`timescale 1ns/10ps
`include "rtc_link_defs.svh"

module rtc_device (
    input wire logic clk,
    input wire logic nrst,
    rtc_link_if.device link,
    output rtc_link_pkg::byte_t stat1,
    output rtc_link_pkg::byte_t stat2,
    output rtc_link_pkg::byte_t corr,
    output rtc_link_pkg::byte_t free,
    output logic [23:0] alarm1,
    output logic [23:0] alarm2,
    output logic first_int_pin_n,
    output logic second_int_pin_n,
    output logic fixed_crystal_freq_output
);
    import rtc_link_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE, D_ADDR, D_ACK, D_WR, D_RD, D_MACK, D_SKIP
    } dev_state_e;

    dev_state_e st_q;
    logic [2:0] cnt_q;
    byte_t sh_q;
    byte_t tx_q;
    cmd_t cmd_q;
    logic rw_q;
    logic [1:0] idx_q;
    logic oe_q;
    logic start_tog_q;
    logic stop_tog_q;
    logic start_seen_q;
    logic stop_seen_q;
    byte_t st1_q;
    byte_t st2_q;
    byte_t corr_q;
    byte_t free_q;
    logic [23:0] first_interrupt_register_q;
    logic [23:0] second_interrupt_register_q;
    logic upd_tog_q;
    logic start_p;
    logic stop_p;
    logic wr_en;
    byte_t in_byte;
    logic [1:0] len;
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_s3_q;
    logic [17:0] fcnt_q [2];
    logic [1:0] pin_q;
    logic [9:0] fix_cnt_q;
    logic fix_q;

    function automatic byte_t rd_byte(cmd_t c, logic [1:0] i);
        logic [23:0] w;
        w = `INT_RST;
        case (c)
            `CMD_STAT1: w = {st1_q, 16'h0000};
            `CMD_STAT2: w = {st2_q, 16'h0000};
            `CMD_FIRST_INTERRUPT_REGISTER: w = first_interrupt_register_q;
            `CMD_SECOND_INTERRUPT_REGISTER: w = second_interrupt_register_q;
            `CMD_CORR: w = {corr_q, 16'h0000};
            `CMD_FREE: w = {free_q, 16'h0000};
            default: w = `INT_RST;
        endcase
        w = w << {i, 3'b000};
        return w[23:16];
    endfunction

    function automatic logic [23:0] put_byte(logic [23:0] w,
                                             logic [1:0] i, byte_t b);
        logic [23:0] r;
        r = w;
        case (i)
            2'h0: r[23:16] = b;
            2'h1: r[15:8] = b;
            default: r[7:0] = b;
        endcase
        return r;
    endfunction

    function automatic logic [17:0] half_cyc(byte_t r);
        return 18'((`FIX_HALF_CYC) * (int'(r) + 1));
    endfunction

    assign start_p = start_tog_q ^ start_seen_q;
    assign stop_p = stop_tog_q ^ stop_seen_q;
    assign in_byte = {sh_q[6:0], link.sda};  // [RQ18]
    assign len = reg_len(cmd_q, st2_q);  // [RQ5] [RQ6]
    assign wr_en = !start_p && st_q == D_WR && cnt_q == 3'h7
        && idx_q < len;

    // Bus conditions seen on data edges while the clock is high;
    // a held-low data line by this end blocks both  [RQ11]
    always_ff @(negedge link.sda or negedge nrst) begin
        if (!nrst) begin
            start_tog_q <= 1'b0;
        end else if (link.scl && !oe_q) begin
            start_tog_q <= ~start_tog_q;
        end
    end

    always_ff @(posedge link.sda or negedge nrst) begin
        if (!nrst) begin
            stop_tog_q <= 1'b0;
        end else if (link.scl && !oe_q) begin
            stop_tog_q <= ~stop_tog_q;  // [RQ11]
        end
    end

    // Toggles settle long before the next rising clock edge
    always_ff @(posedge link.scl or negedge nrst) begin
        if (!nrst) begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
        end else begin
            start_seen_q <= start_tog_q;
            stop_seen_q <= stop_tog_q;
        end
    end

    // Bit engine; without a stop or start nothing here resets  [RQ10]
    always_ff @(posedge link.scl or negedge nrst) begin
        if (!nrst) begin
            st_q <= D_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            cmd_q <= `CMD_STAT1;
            rw_q <= 1'b0;
            idx_q <= 2'h0;
        end else if (start_p) begin
            st_q <= D_ADDR;
            cnt_q <= 3'h1;
            sh_q <= {7'h00, link.sda};
        end else if (stop_p) begin
            st_q <= D_IDLE;  // [RQ10]
        end else begin
            case (st_q)
                D_ADDR: begin
                    sh_q <= in_byte;
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        cmd_q <= in_byte[3:1];
                        rw_q <= in_byte[0];  // [RQ18]
                        idx_q <= 2'h0;
                        if (in_byte[7:4] == `DEV_CODE
                            && in_byte[3:1] != `CMD_TIME1
                            && in_byte[3:1] != `CMD_TIME2) begin
                            st_q <= D_ACK;  // [RQ19]
                        end else begin
                            st_q <= D_SKIP;
                        end
                    end
                end
                D_ACK: begin
                    cnt_q <= 3'h0;
                    if (rw_q) begin
                        st_q <= D_RD;
                        tx_q <= rd_byte(cmd_q, idx_q);  // [RQ1] [RQ2]
                    end else begin
                        st_q <= D_WR;
                    end
                end
                D_WR: begin
                    sh_q <= in_byte;
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        idx_q <= idx_q + 2'h1;
                        st_q <= wr_en ? D_ACK : D_SKIP;  // [RQ19]
                    end
                end
                D_RD: begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    cnt_q <= cnt_q + 3'h1;
                    if (cnt_q == 3'h7) begin
                        st_q <= D_MACK;
                    end
                end
                D_MACK: begin
                    cnt_q <= 3'h0;
                    // Released line means no more bytes wanted  [RQ3]
                    if (!link.sda && idx_q + 2'h1 < len) begin
                        idx_q <= idx_q + 2'h1;
                        tx_q <= rd_byte(cmd_q, idx_q + 2'h1);
                        st_q <= D_RD;
                    end else begin
                        st_q <= D_SKIP;
                    end
                end
                default: st_q <= st_q;
            endcase
        end
    end

    // Data changes only while the clock is low
    always_ff @(negedge link.scl or negedge nrst) begin
        if (!nrst) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= (st_q == D_ACK)
                || (st_q == D_RD && !tx_q[7]);  // [RQ19] [RQ18]
        end
    end

    assign link.sda_d_o = 1'b0;
    assign link.sda_d_oe = oe_q;

    // Register file, written as each byte completes
    always_ff @(posedge link.scl or negedge nrst) begin
        if (!nrst) begin
            st1_q <= `STAT1_RST;
            st2_q <= `STAT2_RST;
            corr_q <= `CORR_RST;
            free_q <= `FREE_RST;
            first_interrupt_register_q <= `INT_RST;
            second_interrupt_register_q <= `INT_RST;
            upd_tog_q <= 1'b0;
        end else if (wr_en) begin
            upd_tog_q <= ~upd_tog_q;
            case (cmd_q)
                `CMD_STAT1: st1_q <= in_byte;  // [RQ1]
                `CMD_STAT2: st2_q <= in_byte;  // [RQ1]
                `CMD_FIRST_INTERRUPT_REGISTER: first_interrupt_register_q <= put_byte(first_interrupt_register_q, idx_q, in_byte);
                `CMD_SECOND_INTERRUPT_REGISTER: second_interrupt_register_q <= put_byte(second_interrupt_register_q, idx_q, in_byte);
                `CMD_CORR: corr_q <= in_byte;
                `CMD_FREE: free_q <= in_byte;
                default: upd_tog_q <= ~upd_tog_q;
            endcase
        end
    end

    // Update toggle crossing; link registers stay still for at least
    // one byte time, far longer than the synchroniser delay
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_s3_q <= 1'b0;
        end else begin
            tog_s1_q <= upd_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_s3_q <= tog_s2_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stat1 <= `STAT1_RST;
            stat2 <= `STAT2_RST;
            corr <= `CORR_RST;
            free <= `FREE_RST;
            alarm1 <= `INT_RST;
            alarm2 <= `INT_RST;
        end else if (tog_s2_q ^ tog_s3_q) begin
            stat1 <= st1_q;
            stat2 <= st2_q;
            corr <= corr_q;
            free <= free_q;
            alarm1 <= first_interrupt_register_q;  // [RQ2]
            alarm2 <= second_interrupt_register_q;  // [RQ2]
        end
    end

    // Interrupt pins: square wave in frequency mode, else released.
    // No time keeping here, so alarm mode never asserts a pin.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fcnt_q[0] <= 18'h0_0000;
            fcnt_q[1] <= 18'h0_0000;
            pin_q <= 2'b11;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (int_mode(stat2, i[0]) != INT_FREQ) begin
                    fcnt_q[i] <= 18'h0_0000;
                    pin_q[i] <= 1'b1;
                end else if (fcnt_q[i] + 18'h0_0001
                             >= half_cyc(i == 0 ? alarm1[23:16]
                                                : alarm2[23:16])) begin
                    fcnt_q[i] <= 18'h0_0000;
                    pin_q[i] <= ~pin_q[i];  // [RQ7]
                end else begin
                    fcnt_q[i] <= fcnt_q[i] + 18'h0_0001;
                end
            end
        end
    end

    assign first_int_pin_n = pin_q[0];
    assign second_int_pin_n = pin_q[1];

    // Fixed output from the system clock; 762-cycle half period
    // leaves a small frequency error against a true crystal
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fix_cnt_q <= 10'h000;
            fix_q <= 1'b0;
        end else if (fix_cnt_q == 10'((`FIX_HALF_CYC) - 1)) begin
            fix_cnt_q <= 10'h000;
            fix_q <= ~fix_q;  // [RQ17]
        end else begin
            fix_cnt_q <= fix_cnt_q + 10'h001;
        end
    end

    assign fixed_crystal_freq_output = fix_q;

endmodule

// ---- src/rtc_link_defs.svh ----
// Constants shared by both ends of the two-wire clock-chip link.
// Assumes inclusion by bare name from the package and both end modules.
`ifndef RTC_LINK_DEFS_SVH
`define RTC_LINK_DEFS_SVH

// Address byte: upper nibble is the device code, value arbitrary
`define DEV_CODE 4'h6

// Command field of the address byte; bit 0 is the selector
`define CMD_STAT1 3'h0
`define CMD_STAT2 3'h1
`define CMD_TIME1 3'h2
`define CMD_TIME2 3'h3
`define CMD_FIRST_INTERRUPT_REGISTER 3'h4
`define CMD_SECOND_INTERRUPT_REGISTER 3'h5
`define CMD_CORR 3'h6
`define CMD_FREE 3'h7

// Two-bit interrupt mode fields inside the second status register
`define ST2_FIRST_INTERRUPT_REGISTER_POS 6
`define ST2_SECOND_INTERRUPT_REGISTER_POS 2

`define STAT1_RST 8'h00
`define STAT2_RST 8'h00
`define CORR_RST 8'h00
`define FREE_RST 8'h00
`define INT_RST 24'h00_0000

`define ALARM_BYTES 2'h3
`define ONE_BYTE 2'h1
`define RECOV_CLKS 6'h3F

`define CLK_HZ 50000000
`define FIX_HZ 32768
`define FIX_HALF_CYC (`CLK_HZ / (2 * `FIX_HZ))
`define PWRUP_MS 500
`define PWRUP_CYCLES (`PWRUP_MS * (`CLK_HZ / 1000))

`endif

// ---- src/rtc_link_pkg.sv ----
// Types and decode helpers shared by both ends of the link.
// Assumes rtc_link_defs.svh is on the include path.
`include "rtc_link_defs.svh"

package rtc_link_pkg;

    typedef logic [2:0] cmd_t;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {INT_OFF, INT_FREQ, INT_ALARM, INT_RSVD} int_mode_e;

    function automatic int_mode_e int_mode(byte_t st2, logic sel);
        if (sel) begin
            return int_mode_e'(st2[`ST2_SECOND_INTERRUPT_REGISTER_POS +: 2]);
        end
        return int_mode_e'(st2[`ST2_FIRST_INTERRUPT_REGISTER_POS +: 2]);
    endfunction

    function automatic logic is_int(cmd_t c);
        return (c == `CMD_FIRST_INTERRUPT_REGISTER) || (c == `CMD_SECOND_INTERRUPT_REGISTER);
    endfunction

    function automatic logic [1:0] reg_len(cmd_t c, byte_t st2);
        if (is_int(c) && int_mode(st2, c[0]) == INT_ALARM) begin
            return `ALARM_BYTES;
        end
        return `ONE_BYTE;
    endfunction

    function automatic logic modes_clash(byte_t st2);
        int_mode_e m1;
        int_mode_e m2;
        m1 = int_mode(st2, 1'b0);
        m2 = int_mode(st2, 1'b1);
        return (m1 == INT_ALARM || m2 == INT_ALARM)
            && (m1 == INT_FREQ || m2 == INT_FREQ);
    endfunction

endpackage

// ---- src/rtc_link_if.sv ----
// Two-wire link between the bus master and the clock chip.
// Assumes both ends drive open-drain enables; the wire level is resolved here.
`timescale 1ns/10ps

interface rtc_link_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic sda;

    // Wired-and with pull-up
    assign sda = (~sda_m_oe | sda_m_o) & (~sda_d_oe | sda_d_o);

    modport master (
        output scl,
        output sda_m_o,
        output sda_m_oe,
        input sda
    );

    modport device (
        input scl,
        input sda,
        output sda_d_o,
        output sda_d_oe
    );
endinterface

// ---- src/rtc_master.sv ----
// Bus master end: makes the link clock from clk and runs transfers.
// Assumes a user issues one request at a time while ready is high.
`timescale 1ns/10ps
`include "rtc_link_defs.svh"

module rtc_master #(
    parameter int unsigned PWRUP_CYCLES = `PWRUP_CYCLES
) (
    input wire logic clk,
    input wire logic nrst,
    rtc_link_if.master link,
    input wire logic req,
    input rtc_link_pkg::cmd_t req_cmd,
    input wire logic req_rd,
    input wire logic [23:0] req_wdata,
    input wire logic recover,
    output logic ready,
    output logic refused,
    output logic rd_valid,
    output rtc_link_pkg::byte_t rd_data,
    output logic done,
    output logic nack
);
    import rtc_link_pkg::*;

    typedef enum logic [2:0] {M_PWRUP, M_IDLE, M_START, M_BIT, M_STOP}
        mst_state_e;

    mst_state_e st_q;
    logic [2:0] ph_q;
    logic [24:0] wait_q;
    logic recov_q;
    logic [5:0] pulse_q;
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic [1:0] len_q;
    logic rd_q;
    byte_t sh_q;
    logic [23:0] wbuf_q;
    logic low_q;
    logic s1_q;
    logic s2_q;
    byte_t st2_sh_q;
    logic st2_known_q;
    logic scl_q;
    logic oe_q;
    logic tick;
    logic rx;
    logic last;
    logic refuse_c;
    logic go_c;

    assign tick = ph_q == 3'h7;
    assign rx = rd_q && byte_q != 2'h0;
    assign last = byte_q == len_q;
    // Time data is not handled here, so no readback window opens [RQ16]
    assign refuse_c = req_cmd == `CMD_TIME1 || req_cmd == `CMD_TIME2
        || (is_int(req_cmd) && !st2_known_q)  // [RQ8]
        || (req_cmd == `CMD_STAT2 && !req_rd
            && modes_clash(req_wdata[23:16]));  // [RQ9]
    assign go_c = st_q == M_IDLE && (recover || (req && !refuse_c));
    assign ready = st_q == M_IDLE;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
        end else begin
            s1_q <= link.sda;
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ph_q <= 3'h0;
        end else if (go_c || (st_q == M_PWRUP && wait_q == '0)) begin
            ph_q <= 3'h0;
        end else begin
            ph_q <= ph_q + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= M_PWRUP;
            wait_q <= 25'(PWRUP_CYCLES - 1);
            recov_q <= 1'b0;
            pulse_q <= 6'h00;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            len_q <= 2'h0;
            rd_q <= 1'b0;
            sh_q <= 8'h00;
            wbuf_q <= 24'h00_0000;
            st2_sh_q <= `STAT2_RST;
            st2_known_q <= 1'b0;
            nack <= 1'b0;
            done <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            refused <= 1'b0;
        end else begin
            done <= 1'b0;
            rd_valid <= 1'b0;
            refused <= st_q == M_IDLE && req && !recover && refuse_c;
            case (st_q)
                M_PWRUP: begin
                    // Quiet power-on wait, then recovery  [RQ15] [RQ14]
                    wait_q <= wait_q - 25'h000_0001;
                    if (wait_q == '0) begin
                        st_q <= M_START;
                        recov_q <= 1'b1;
                        pulse_q <= 6'h00;
                    end
                end
                M_IDLE: begin
                    if (go_c) begin
                        st_q <= M_START;
                        recov_q <= recover;
                        pulse_q <= 6'h00;
                        bit_q <= 4'h0;
                        byte_q <= 2'h0;
                        nack <= 1'b0;
                        // Recovery must not take a stale request's data
                        if (!recover) begin
                            cmd_q_load(req_cmd);
                        end
                    end
                end
                M_START: begin
                    if (tick) begin
                        st_q <= M_BIT;
                        bit_q <= 4'h0;
                    end
                end
                M_BIT: begin
                    if (tick && recov_q) begin
                        pulse_q <= pulse_q + 6'h01;
                        if (pulse_q == `RECOV_CLKS - 6'h01) begin
                            st_q <= M_STOP;  // [RQ12] [RQ13]
                        end
                    end else if (tick && bit_q != 4'h8) begin
                        bit_q <= bit_q + 4'h1;
                        sh_q <= {sh_q[6:0], s2_q};
                        if (bit_q == 4'h7 && rx) begin
                            rd_valid <= 1'b1;
                            rd_data <= {sh_q[6:0], s2_q};
                        end
                    end else if (tick) begin
                        bit_q <= 4'h0;
                        if (!rx && s2_q) begin
                            nack <= 1'b1;
                            st_q <= M_STOP;
                        end else if (last) begin
                            st_q <= M_STOP;
                        end else begin
                            byte_q <= byte_q + 2'h1;
                            sh_q <= wbuf_q[23:16];
                            wbuf_q <= {wbuf_q[15:0], 8'h00};
                        end
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        st_q <= M_IDLE;
                        done <= 1'b1;
                    end
                end
                default: st_q <= M_IDLE;
            endcase
        end
    end

    // Request capture kept apart for readability of the state machine
    task automatic cmd_q_load(cmd_t c);
        rd_q <= req_rd;
        wbuf_q <= req_wdata;
        len_q <= reg_len(c, st2_sh_q);
        sh_q <= {`DEV_CODE, c, req_rd};  // [RQ1] [RQ2]
        if (c == `CMD_STAT2 && !req_rd) begin
            st2_sh_q <= req_wdata[23:16];
            st2_known_q <= 1'b1;
        end
    endtask

    // Data drive, changed a cycle into the low half of each clock
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_q <= 1'b0;
        end else if (st_q == M_START) begin
            low_q <= 1'b1;
        end else if (st_q == M_BIT && ph_q == 3'h1) begin
            if (recov_q) begin
                low_q <= 1'b0;  // [RQ12]
            end else if (bit_q != 4'h8) begin
                low_q <= rx ? 1'b0 : !sh_q[7];
            end else begin
                low_q <= rx && !last;  // [RQ3] [RQ4]
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            case (st_q)
                M_START: begin
                    scl_q <= 1'b1;
                    oe_q <= ph_q >= 3'h4;
                end
                M_BIT: begin
                    scl_q <= ph_q >= 3'h4;
                    oe_q <= low_q;
                end
                M_STOP: begin
                    scl_q <= ph_q >= 3'h4;
                    oe_q <= (ph_q == 3'h0) ? low_q : ph_q < 3'h6;
                end
                default: begin
                    scl_q <= 1'b1;
                    oe_q <= 1'b0;
                end
            endcase
        end
    end

    assign link.scl = scl_q;
    assign link.sda_m_o = 1'b0;
    assign link.sda_m_oe = oe_q;

endmodule

// ---- tb/rtc_link_chk.sv ----
// Checker on the wires between the master and the clock-chip ends.
// Assumes scl is a flop of clk, so clk samples the link cleanly.
`timescale 1ns/10ps
module rtc_link_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe,
    input wire logic sda
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    dev_edge_a: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device data moved while scl high");
    dev_hold_a: assert property (
        scl && $past(scl) |-> $stable(sda_d_oe))
        else $error("device data unstable in scl high");
    low_half_a: assert property ($fell(scl) |-> !scl [*4] ##1 scl)
        else $error("scl low half not four cycles");
    high_half_a: assert property ($rose(scl) |-> scl [*4])
        else $error("scl high half too short");
    dev_release_a: assert property (
        $rose(sda_d_oe) |-> ##[1:80] !sda_d_oe)
        else $error("device held data line too long");
    stop_quiet_a: assert property (
        scl && $past(scl) && $rose(sda) |-> !sda_d_oe [*8])
        else $error("device drove after stop");
    // Both ends may overlap just after scl falls, never with scl high
    drive_clash_a: assert property (
        sda_d_oe && sda_m_oe |-> !scl)
        else $error("both ends drive the data line with scl high");
    start_hold_a: assert property (
        scl && $past(scl) && $fell(sda) |-> scl [*2])
        else $error("scl dropped right after start");
endmodule

// ---- tb/test_rtc_serial_register_access.sv ----
// Bench joining both link ends; user side driven, reads queued.
// Assumes the package, interface and both ends from src/.
`timescale 1ns/10ps
`include "rtc_link_defs.svh"
module test_rtc_serial_register_access;
    import rtc_link_pkg::*;
    logic clk = 0, nrst = 0, req = 0, req_rd = 0, recover = 0;
    cmd_t req_cmd = '0;
    logic [23:0] req_wdata = '0, alarm1, alarm2;
    logic ready, refused, rd_valid, done, nack;
    logic first_int_pin_n, second_int_pin_n, fixed_crystal_freq_output;
    byte_t rd_data, stat1, stat2, corr, free, exp_q[$];
    int mismatches = 0, check_count = 0, cyc = 0;
    logic [31:0] rnd = 32'h2071_9e4d;
    rtc_link_if link ();
    rtc_master #(.PWRUP_CYCLES(20)) i_rtc_master (.clk, .nrst,
        .link(link), .req, .req_cmd, .req_rd, .req_wdata, .recover,
        .ready, .refused, .rd_valid, .rd_data, .done, .nack);
    rtc_device i_rtc_device (.clk, .nrst, .link(link), .stat1, .stat2,
        .corr, .free, .alarm1, .alarm2, .first_int_pin_n,
        .second_int_pin_n, .fixed_crystal_freq_output);
    rtc_link_chk i_rtc_link_chk (.clk, .nrst, .scl(link.scl),
        .sda_m_oe(link.sda_m_oe), .sda_d_oe(link.sda_d_oe), .sda(link.sda));
    initial begin
        forever #10 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C1_1DB7 : 32'h0);
    endfunction
    task automatic chk(string n, logic [23:0] e, logic [23:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Reads push the bytes they expect; the monitor below pops them
    task automatic op(cmd_t c, logic r, logic [23:0] w, int n, logic rf);
        int i;
        for (i = 0; i < n; i++) exp_q.push_back(w[23-8*i -: 8]);
        while (ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req <= 1;
        req_cmd <= c;
        req_rd <= r;
        req_wdata <= w;
        @(posedge clk);
        req <= 0;
        i = 0;
        while (!(done | refused) && i < 3000) begin
            @(negedge clk);
            i++;
        end
        chk("refused", rf, refused);
        if (!rf) chk("nack", 0, nack);
    endtask
    // Half period in clk cycles between two changes of a pin
    task automatic half(string n, ref logic s, input int e);
        logic v;
        int k;
        for (int j = 0; j < 2; j++) begin
            v = s;
            k = 0;
            while (s === v && k < 3000) begin
                @(negedge clk);
                k++;
            end
        end
        chk(n, e, k);
    endtask
    always @(negedge clk) begin
        if (rd_valid)
            chk("rd_data", exp_q.size() ? exp_q.pop_front() : 'x,
                rd_data);
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        byte_t b;
        cmd_t plain[3] = '{`CMD_STAT1, `CMD_CORR, `CMD_FREE};
        repeat (4) @(posedge clk);
        nrst <= 1;
        while (done !== 1'b1) @(negedge clk);
        op(`CMD_FIRST_INTERRUPT_REGISTER, 0, 24'h0, 0, 1);
        op(`CMD_TIME1, 1, 24'h0, 0, 1);
        op(`CMD_STAT2, 0, {3{8'h84}}, 0, 1);
        foreach (plain[j]) begin
            rnd = lfsr(rnd);
            b = rnd[7:0];
            op(plain[j], 0, {3{b}}, 0, 0);
            chk("reg out", b, j == 0 ? stat1 : j == 1 ? corr : free);
            op(plain[j], 1, {3{b}}, 1, 0);
        end
        chk("free", b, free);
        op(`CMD_STAT2, 0, {3{8'h80}}, 0, 0);
        chk("stat2", 8'h80, stat2);
        rnd = lfsr(rnd);
        op(`CMD_FIRST_INTERRUPT_REGISTER, 0, rnd[23:0], 0, 0);
        op(`CMD_FIRST_INTERRUPT_REGISTER, 1, rnd[23:0], 3, 0);
        chk("alarm1", rnd[23:0], alarm1);
        op(`CMD_SECOND_INTERRUPT_REGISTER, 0, {3{8'h5A}}, 0, 0);
        chk("alarm2", 24'h5A_0000, alarm2);
        op(`CMD_SECOND_INTERRUPT_REGISTER, 1, {3{8'h5A}}, 1, 0);
        chk("alarm1 kept", rnd[23:0], alarm1);
        op(`CMD_STAT2, 0, {3{8'h04}}, 0, 0);
        op(`CMD_SECOND_INTERRUPT_REGISTER, 0, 24'h0, 0, 0);
        half("second_interrupt_register pin", second_int_pin_n, 762);
        chk("alarm2 freq", 24'h00_0000, alarm2);
        chk("first_interrupt_register pin", 1, first_int_pin_n);
        half("fixed out", fixed_crystal_freq_output, 762);
        @(posedge clk);
        recover <= 1;
        @(posedge clk);
        recover <= 0;
        repeat (600) @(negedge clk) if (done) break;
        chk("recovery done", 1, done);
        op(`CMD_FREE, 1, {3{b}}, 1, 0);
        repeat (20) @(negedge clk);
        chk("reads left", 0, exp_q.size());
        stop_test();
    end
endmodule
